// >>> hdl/cfg_load_pkg.sv
package cfg_load_pkg;

	// ---------------------------------------------------------------
	// clock and power-on timing
	// ---------------------------------------------------------------
	localparam int REF_CLK_MHZ     = 200;
	localparam int POR_DELAY_US    = 16000;
	localparam int POR_CYC         = POR_DELAY_US * REF_CLK_MHZ;
	localparam int POR_MASTER_MULT = 4;
	localparam int MODE_SETTLE_CYC = 2;
	localparam int SLOW_CLK_KHZ    = 1000;
	localparam int SLOW_HALF_CYC   = (REF_CLK_MHZ * 1000) / (2 * SLOW_CLK_KHZ);
	localparam int CLK_FAST_MULT   = 8;

	// ---------------------------------------------------------------
	// frame geometry
	// ---------------------------------------------------------------
	localparam int ROW_BITS     = 10;
	localparam int TOP_BITS     = 7;
	localparam int BOT_BITS     = 13;
	localparam int ONE_BIT      = 1;
	localparam int START_BITS   = 1;
	localparam int CHECK_BITS   = 4;
	localparam int COL_FRAMES   = 36;
	localparam int LEFT_FRAMES  = 26;
	localparam int RIGHT_FRAMES = 41;
	localparam int EXTRA_FRAMES = 1;
	localparam int LEN_BITS     = 24;

	// ---------------------------------------------------------------
	// stream codes
	// ---------------------------------------------------------------
	localparam logic [3:0] PREAMBLE     = 4'h2;
	localparam logic [3:0] CONST_CHECK  = 4'h6;
	localparam logic [7:0] EXP_PREAMBLE = 8'hF2;
	localparam logic [7:0] EXP_START    = 8'hFE;
	localparam logic [7:0] EXP_CHECK    = 8'hD2;
	localparam int         EXP_SKIP     = 6;
	localparam int         FAST_BIT_POS = 2;
	localparam int         CRC_BIT_POS  = 3;
	localparam logic [15:0] CRC16_POLY  = 16'h1021;
	localparam logic [15:0] CRC16_INIT  = 16'h0000;
	localparam int         RB_CRC_BITS  = 11;

	// ---------------------------------------------------------------
	// mode pins
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_MASTER = 2'h2;
	localparam logic [1:0] MODE_SLAVE  = 2'h3;

	typedef enum logic [2:0] {
		R_CLEAR  = 3'b000,
		R_LAST   = 3'b001,
		R_INIT   = 3'b010,
		R_MODE   = 3'b011,
		R_CONFIG = 3'b100,
		R_ERROR  = 3'b101,
		R_DONE   = 3'b110
	} ref_state_t;

	typedef enum logic [2:0] {
		L_IDLE  = 3'b000,
		L_HEAD  = 3'b001,
		L_LEN   = 3'b010,
		L_START = 3'b011,
		L_FRAME = 3'b100,
		L_PASS  = 3'b101,
		L_ERR   = 3'b110
	} link_state_t;

	typedef struct packed {
		logic go;
		logic express;
	} link_ctl_t;

	typedef struct packed {
		logic err;
		logic done;
		logic fast;
	} link_stat_t;

endpackage

// >>> hdl/config_load_sequencer.sv
`timescale 1ns/1ps
module config_load_sequencer
	import cfg_load_pkg::*;
#(
	parameter int ROWS          = 10,
	parameter int COLS          = 10,
	parameter int EXT           = 0,
	parameter int POR_DELAY_CYC = POR_CYC,
	parameter int SLOW_HALF     = SLOW_HALF_CYC
) (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       cfg_clk_i,
	input  wire logic       reprogram_n_i,
	input  wire logic       status_n_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       din_i,
	input  wire logic [7:0] data_byte_i,
	input  wire logic       rb_en_i,
	input  wire logic       rb_bit_i,
	output logic            status_n_o,
	output logic            status_n_oe_o,
	output logic            done_o,
	output logic            done_oe_o,
	output logic            low_during_config_o,
	output logic            high_during_config_o,
	output logic            config_clock_o,
	output logic            config_clock_oe_o,
	output logic            chain_out_o,
	output logic            rb_data_o,
	output logic            rb_busy_o
);

	localparam int FRAME_BITS = ROW_BITS * ROWS + TOP_BITS + BOT_BITS + ONE_BIT
		+ START_BITS + CHECK_BITS + EXT;
	localparam int FRAMES = COL_FRAMES * COLS + LEFT_FRAMES + RIGHT_FRAMES
		+ EXTRA_FRAMES + EXT;
	localparam int SER_UNITS = FRAME_BITS - START_BITS;
	localparam int EXP_UNITS = (FRAME_BITS + 7) / 8 + 1;
	localparam int FA_W      = 11;
	localparam int CNT_W     = 9;
	localparam int POR_W     = 26;
	localparam int DIV_W     = 8;

	generate
		if (FRAMES > (1 << FA_W) || SER_UNITS >= (1 << CNT_W)) begin : g_bad_geom
			$error("frame geometry too large for counters");
		end
		if (POR_DELAY_CYC * POR_MASTER_MULT >= (1 << POR_W) || POR_DELAY_CYC < 1) begin : g_bad_por
			$error("power-on delay out of range");
		end
		if (SLOW_HALF >= (1 << DIV_W) || SLOW_HALF % CLK_FAST_MULT != 0) begin : g_bad_div
			$error("clock divider must be a multiple of the fast ratio");
		end
	endgenerate

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
		crc16_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
	endfunction

	// ---------------------------------------------------------------
	// reference domain: pin and link status synchronisers
	// ---------------------------------------------------------------
	logic [1:0] prog_sync_reg, stat_sync_reg;
	logic [3:0] mode_sync_reg;
	link_stat_t lstat_meta_reg, lstat_reg, lstat_next;
	logic       prog_low, master_live;
	logic [1:0] lep_sync_reg;
	logic       lepoch_reg, epoch_reg, epoch_ok_reg, stat_fresh;

	always_ff @(posedge ref_clk_i) begin
		prog_sync_reg  <= {prog_sync_reg[0], reprogram_n_i};
		stat_sync_reg  <= {stat_sync_reg[0], status_n_i};
		mode_sync_reg  <= {mode_sync_reg[1:0], mode_i};
		lstat_meta_reg <= lstat_next;
		lstat_reg      <= lstat_meta_reg;
		lep_sync_reg   <= {lep_sync_reg[0], lepoch_reg};
	end

	assign prog_low    = ~prog_sync_reg[1];
	assign master_live = (mode_sync_reg[3:2] == MODE_MASTER);

	// ---------------------------------------------------------------
	// reference domain: clear, init and mode sequencing
	// ---------------------------------------------------------------
	ref_state_t        state_reg;
	logic [FA_W-1:0]   faddr_reg;
	logic [POR_W-1:0]  por_cnt_reg;
	logic              por_active_reg;
	logic [1:0]        settle_reg;
	logic [1:0]        mode_reg;
	link_ctl_t         lctl_reg;
	logic              pass_end;

	assign pass_end = (faddr_reg == FA_W'(FRAMES - 1));

	// power-up delay runs once from reset, never on reprogram
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			por_cnt_reg    <= '0;
			por_active_reg <= 1'b1;
		end else if (por_active_reg) begin
			por_cnt_reg <= por_cnt_reg + 1'b1;
			if (por_cnt_reg >= POR_W'(master_live ? POR_DELAY_CYC * POR_MASTER_MULT
					: POR_DELAY_CYC) - 1'b1) begin
				por_active_reg <= 1'b0;
			end
		end
	end

	// frame address walks on every cycle of a clearing pass
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || prog_low || (state_reg != R_CLEAR && state_reg != R_LAST)) begin
			faddr_reg <= '0;
		end else begin
			faddr_reg <= pass_end ? '0 : faddr_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state_reg  <= R_CLEAR;
			settle_reg <= '0;
			mode_reg   <= '0;
		end else if (prog_low) begin
			state_reg <= R_CLEAR;
		end else begin
			case (state_reg)
				R_CLEAR: begin
					if (pass_end && !por_active_reg) begin
						state_reg <= R_LAST;
					end
				end
				R_LAST: begin
					if (pass_end) begin
						state_reg <= R_INIT;
					end
				end
				R_INIT: begin
					settle_reg <= '0;
					// an outside low on status holds us here
					if (stat_sync_reg[1]) begin
						state_reg <= R_MODE;
					end
				end
				R_MODE: begin
					settle_reg <= settle_reg + 1'b1;
					if (settle_reg == 2'(MODE_SETTLE_CYC - 1)) begin
						mode_reg  <= mode_sync_reg[3:2];
						state_reg <= R_CONFIG;
					end
				end
				R_CONFIG: begin
					if (stat_fresh && lstat_reg.err) begin
						state_reg <= R_ERROR;
					end else if (stat_fresh && lstat_reg.done) begin
						state_reg <= R_DONE;
					end
				end
				R_ERROR: state_reg <= R_ERROR;
				R_DONE: state_reg <= R_DONE;
				default: state_reg <= R_CLEAR;
			endcase
		end
	end

	// a link clock that stood still leaves stale status behind; status is
	// trusted only once the link has echoed the current restart epoch
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			epoch_reg    <= 1'b0;
			epoch_ok_reg <= 1'b0;
		end else begin
			if (prog_low && state_reg != R_CLEAR) begin
				epoch_reg <= ~epoch_reg;
			end
			epoch_ok_reg <= (lep_sync_reg[1] == epoch_reg);
		end
	end

	assign stat_fresh = epoch_ok_reg && (lep_sync_reg[1] == epoch_reg);

	// ---------------------------------------------------------------
	// reference domain: pins and master clock divider
	// ---------------------------------------------------------------
	logic [DIV_W-1:0] div_reg;
	logic             config_clock_run;

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			status_n_o           <= 1'b0;
			status_n_oe_o        <= 1'b1;
			done_o               <= 1'b0;
			done_oe_o            <= 1'b1;
			low_during_config_o  <= 1'b0;
			high_during_config_o <= 1'b1;
			lctl_reg             <= '0;
		end else begin
			status_n_o    <= 1'b0;
			status_n_oe_o <= prog_low || state_reg == R_CLEAR || state_reg == R_LAST
				|| state_reg == R_ERROR;
			done_o        <= 1'b0;
			done_oe_o     <= (state_reg != R_DONE);
			low_during_config_o  <= (state_reg == R_DONE);
			high_during_config_o <= (state_reg != R_DONE);
			lctl_reg.go      <= (state_reg == R_CONFIG || state_reg == R_ERROR
				|| state_reg == R_DONE) && !prog_low;
			lctl_reg.express <= ~mode_reg[1];
		end
	end

	assign config_clock_run = (mode_reg == MODE_MASTER) && (state_reg == R_CONFIG
		|| state_reg == R_ERROR || state_reg == R_DONE);

	// slow rate until the stream's fast-clock bit is seen
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || !config_clock_run) begin
			div_reg           <= '0;
			config_clock_o    <= 1'b0;
			config_clock_oe_o <= 1'b0;
		end else begin
			config_clock_oe_o <= 1'b1;
			if (div_reg >= DIV_W'(lstat_reg.fast ? SLOW_HALF / CLK_FAST_MULT
					: SLOW_HALF) - 1'b1) begin
				div_reg        <= '0;
				config_clock_o <= ~config_clock_o;
			end else begin
				div_reg <= div_reg + 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// link domain: reset and control crossing
	// ---------------------------------------------------------------
	logic [1:0]  lrst_sync_reg;
	link_ctl_t   lctl_meta_reg, lctl_sync_reg;
	logic        lrun;
	logic [1:0]  epoch_sync_reg;

	always_ff @(posedge cfg_clk_i) begin
		lrst_sync_reg  <= {lrst_sync_reg[0], nrst_i};
		lctl_meta_reg  <= lctl_reg;
		lctl_sync_reg  <= lctl_meta_reg;
		epoch_sync_reg <= {epoch_sync_reg[0], epoch_reg};
		lepoch_reg     <= epoch_sync_reg[1];
	end

	// a new epoch resets the parser for one clock even if go never dropped
	assign lrun = lrst_sync_reg[1] && lctl_sync_reg.go
		&& (lepoch_reg == epoch_sync_reg[1]);

	// ---------------------------------------------------------------
	// link domain: stream parser
	// ---------------------------------------------------------------
	link_state_t          lstate_reg;
	logic [LEN_BITS-1:0]  len_reg, ccnt_reg;
	logic [CNT_W-1:0]     ucnt_reg;
	logic [FA_W-1:0]      fcnt_reg;
	logic [2:0]           sh_reg;
	logic [15:0]          crc_reg;
	logic                 crc_on_reg, first_reg, full_reg;
	logic                 exp_mode, unit_last, check_ok;
	logic [3:0]           ser_win;

	assign exp_mode  = lctl_sync_reg.express;
	assign ser_win   = {sh_reg, din_i};
	assign unit_last = (ucnt_reg == CNT_W'((exp_mode ? EXP_UNITS : SER_UNITS) - 1));
	assign check_ok  = exp_mode ? (data_byte_i == EXP_CHECK)
		: (ser_win == (crc_on_reg ? crc_reg[15:12] : CONST_CHECK));

	// every link clock after memory init counts, extra ones included
	always_ff @(posedge cfg_clk_i) begin
		if (!lrun) begin
			ccnt_reg <= '0;
		end else begin
			ccnt_reg <= ccnt_reg + 1'b1;
		end
	end

	always_ff @(posedge cfg_clk_i) begin
		if (!lrun) begin
			lstate_reg <= L_IDLE;
			len_reg    <= '0;
			ucnt_reg   <= '0;
			fcnt_reg   <= '0;
			sh_reg     <= '0;
			crc_reg    <= CRC16_INIT;
			crc_on_reg <= 1'b0;
			first_reg  <= 1'b1;
			full_reg   <= 1'b0;
			lstat_next <= '0;
		end else begin
			sh_reg <= ser_win[2:0];
			case (lstate_reg)
				L_IDLE: lstate_reg <= L_HEAD;
				L_HEAD: begin
					ucnt_reg <= '0;
					// leading ones simply never match the preamble
					if (exp_mode ? data_byte_i == EXP_PREAMBLE : ser_win == PREAMBLE) begin
						lstate_reg <= L_LEN;
					end
				end
				L_LEN: begin
					ucnt_reg <= ucnt_reg + 1'b1;
					if (!exp_mode) begin
						len_reg <= {len_reg[LEN_BITS-2:0], din_i};
					end
					if (ucnt_reg == CNT_W'((exp_mode ? EXP_SKIP : LEN_BITS) - 1)) begin
						lstate_reg <= L_START;
					end
				end
				L_START: begin
					ucnt_reg <= '0;
					// trailing ones and fill are skipped until a start field
					if (exp_mode ? data_byte_i == EXP_START : !din_i) begin
						lstate_reg <= L_FRAME;
					end
				end
				L_FRAME: begin
					ucnt_reg <= ucnt_reg + 1'b1;
					if (!exp_mode && ucnt_reg < CNT_W'(SER_UNITS - CHECK_BITS)) begin
						crc_reg <= crc16_step(crc_reg, din_i);
						if (first_reg && ucnt_reg == CNT_W'(FAST_BIT_POS)) begin
							lstat_next.fast <= din_i;
						end
						if (first_reg && ucnt_reg == CNT_W'(CRC_BIT_POS)) begin
							crc_on_reg <= din_i;
						end
					end
					if (unit_last) begin
						first_reg <= 1'b0;
						if (!check_ok) begin
							lstate_reg     <= L_ERR;
							lstat_next.err <= 1'b1;
						end else if (fcnt_reg == FA_W'(FRAMES - 1)) begin
							lstate_reg <= L_PASS;
							full_reg   <= 1'b1;
						end else begin
							fcnt_reg   <= fcnt_reg + 1'b1;
							lstate_reg <= L_START;
						end
					end
				end
				L_PASS: begin
					// serial needs length met exactly; byte mode only full
					if (exp_mode || ccnt_reg == len_reg) begin
						lstat_next.done <= 1'b1;
					end
				end
				L_ERR: lstate_reg <= L_ERR;
				default: lstate_reg <= L_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// link domain: daisy-chain output
	// ---------------------------------------------------------------
	always_ff @(posedge cfg_clk_i) begin
		if (!lrst_sync_reg[1]) begin
			chain_out_o <= 1'b1;
		end else if (exp_mode) begin
			chain_out_o <= full_reg;
		end else if (lstate_reg == L_PASS) begin
			chain_out_o <= din_i;
		end else if (lstate_reg == L_START || lstate_reg == L_FRAME
				|| lstate_reg == L_ERR) begin
			chain_out_o <= 1'b1;
		end else begin
			chain_out_o <= din_i;
		end
	end

	// ---------------------------------------------------------------
	// link domain: readback checksum
	// ---------------------------------------------------------------
	logic [15:0] rb_crc_reg;
	logic [3:0]  rb_cnt_reg;
	logic        rb_tail_reg;

	always_ff @(posedge cfg_clk_i) begin
		if (!lrst_sync_reg[1]) begin
			rb_crc_reg  <= CRC16_INIT;
			rb_cnt_reg  <= '0;
			rb_tail_reg <= 1'b0;
			rb_data_o   <= 1'b1;
			rb_busy_o   <= 1'b0;
		end else if (rb_en_i) begin
			rb_data_o   <= rb_bit_i;
			rb_crc_reg  <= crc16_step(rb_crc_reg, rb_bit_i);
			rb_busy_o   <= 1'b1;
			rb_tail_reg <= 1'b1;
			rb_cnt_reg  <= '0;
		end else if (rb_tail_reg) begin
			rb_data_o  <= rb_crc_reg[15];
			rb_crc_reg <= {rb_crc_reg[14:0], 1'b0};
			rb_cnt_reg <= rb_cnt_reg + 1'b1;
			if (rb_cnt_reg == 4'(RB_CRC_BITS - 1)) begin
				rb_tail_reg <= 1'b0;
				rb_crc_reg  <= CRC16_INIT;
			end
		end else begin
			rb_data_o <= 1'b1;
			rb_busy_o <= 1'b0;
		end
	end

endmodule // config_load_sequencer

// >>> testbench/config_load_sequencer_monitor.sv
`timescale 1ns/1ps
module config_load_sequencer_monitor (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic cfg_clk_i,
	input wire logic reprogram_n_i,
	input wire logic rb_en_i,
	input wire logic status_n_o,
	input wire logic status_n_oe_o,
	input wire logic done_o,
	input wire logic done_oe_o,
	input wire logic low_during_config_o,
	input wire logic high_during_config_o,
	input wire logic rb_busy_o
);
	// ----
	// pin checks
	// ----
	sequence reprog_held;
		$fell(reprogram_n_i) ##1 !reprogram_n_i [*3];
	endsequence
	// the checksum is eleven bits, so busy must outlast eight clocks
	sequence crc_tail;
		rb_busy_o [*8] ##[2:7] !rb_busy_o;
	endsequence

	open_drain_pins_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) !status_n_o && !done_o)
		else $error("open-drain pin driven high");
	cfg_levels_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) high_during_config_o != low_during_config_o)
		else $error("config level pins agree");
	done_levels_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) done_oe_o == high_during_config_o)
		else $error("done and config level disagree");
	reprog_status_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) reprog_held |-> ##[0:3] status_n_oe_o)
		else $error("status not pulled on reprogram");
	reprog_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) !reprogram_n_i [*8] |-> status_n_oe_o)
		else $error("status released during reprogram");
	done_persist_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) !done_oe_o && reprogram_n_i |=> !done_oe_o)
		else $error("done dropped without restart");
	done_clean_a: assert property (
		@(posedge ref_clk_i) disable iff (!nrst_i) $fell(done_oe_o) |-> !status_n_oe_o)
		else $error("done released while status low");
	rb_start_a: assert property (
		@(posedge cfg_clk_i) disable iff (!nrst_i) rb_en_i |=> rb_busy_o)
		else $error("readback busy missing");
	rb_crc_a: assert property (
		@(posedge cfg_clk_i) disable iff (!nrst_i) $fell(rb_en_i) |-> crc_tail)
		else $error("readback checksum length wrong");
endmodule // config_load_sequencer_monitor

bind config_load_sequencer config_load_sequencer_monitor config_load_sequencer_monitor_i (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cfg_clk_i(cfg_clk_i),
	.reprogram_n_i(reprogram_n_i), .rb_en_i(rb_en_i), .status_n_o(status_n_o),
	.status_n_oe_o(status_n_oe_o), .done_o(done_o), .done_oe_o(done_oe_o),
	.low_during_config_o(low_during_config_o),
	.high_during_config_o(high_during_config_o), .rb_busy_o(rb_busy_o)
);

// >>> testbench/cfg_stream_source.sv
`timescale 1ns/1ps
module cfg_stream_source
	import cfg_load_pkg::*;
#(
	parameter int FB  = 36,
	parameter int FR  = 104,
	parameter int LEN = 3792
) (
	input  wire logic       run_i,
	input  wire logic [7:0] bad_i,
	output logic            cfg_clk_o,
	output logic            din_o,
	output logic [15:0]     idx_o
);
	// ----
	// serial stream
	// ----
	function automatic logic bit_at(input int n);
		int f;
		int p;
		f = (n - 40) / FB;
		p = (n - 40) % FB;
		if (n < 8 || (n >= 36 && n < 40))
			return 1'b1;
		if (n < 12)
			return PREAMBLE[11 - n];
		if (n < 36)
			return LEN[35 - n];
		if (f < FR && p < FB - 4)
			return 1'b0;
		if (f < FR)
			return f == bad_i || CONST_CHECK[FB - 1 - p];
		if (n < 40 + FR * FB + 8)
			return n != 40 + FR * FB;
		return n % 3 == 0;
	endfunction

	// clock parks low between runs; it keeps going past the count for start-up
	initial begin
		cfg_clk_o = 1'b0;
		idx_o = 16'h0000;
		din_o = 1'b1;
		#0.7;
		forever begin
			#24;
			if (run_i || cfg_clk_o)
				cfg_clk_o = ~cfg_clk_o;
		end
	end

	always @(posedge cfg_clk_o or negedge run_i)
		if (!run_i) begin
			idx_o <= 16'h0000;
			din_o <= 1'b1;
		end else begin
			idx_o <= idx_o + 16'h0001;
			din_o <= bit_at(int'(idx_o) + 1);
		end
endmodule // cfg_stream_source

// >>> testbench/config_load_sequencer_test.sv
`timescale 1ns/1ps
module config_load_sequencer_test;
	import cfg_load_pkg::*;
	localparam int FB  = ROW_BITS + TOP_BITS + BOT_BITS + ONE_BIT + START_BITS + CHECK_BITS;
	localparam int FR  = COL_FRAMES + LEFT_FRAMES + RIGHT_FRAMES + EXTRA_FRAMES;
	localparam int LEN = 48 + FR * FB;
	localparam int POR = 2000;
	localparam logic [15:0] RB_PAT = 16'hA5C3;

	logic        ref_clk;
	logic        nrst;
	logic        reprogram_n;
	logic        run;
	logic [7:0]  bad;
	logic        rb_en;
	logic        rb_bit;
	logic        chk_chain;
	logic        prev_din;
	logic        cfg_clk;
	logic        din;
	logic [15:0] idx;
	logic        st_oe;
	logic        dn_oe;
	logic        lo_cfg;
	logic        hi_cfg;
	logic        chain;
	logic        rb_data;
	logic        rb_busy;
	int          err_count;
	int          samples_checked;
	wire logic   status_wire;

	assign status_wire = ~st_oe;

	config_load_sequencer #(
		.ROWS(1), .COLS(1), .EXT(0), .POR_DELAY_CYC(POR), .SLOW_HALF(8)
	) config_load_sequencer_i (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .cfg_clk_i(cfg_clk),
		.reprogram_n_i(reprogram_n), .status_n_i(status_wire), .mode_i(MODE_SLAVE),
		.din_i(din), .data_byte_i(8'hFF), .rb_en_i(rb_en), .rb_bit_i(rb_bit),
		.status_n_o(), .status_n_oe_o(st_oe), .done_o(), .done_oe_o(dn_oe),
		.low_during_config_o(lo_cfg), .high_during_config_o(hi_cfg),
		.config_clock_o(), .config_clock_oe_o(), .chain_out_o(chain),
		.rb_data_o(rb_data), .rb_busy_o(rb_busy)
	);

	cfg_stream_source #(.FB(FB), .FR(FR), .LEN(LEN)) cfg_stream_source_i (
		.run_i(run), .bad_i(bad), .cfg_clk_o(cfg_clk), .din_o(din), .idx_o(idx)
	);

	always #2.5 ref_clk = ~ref_clk;

	// ----
	// checking
	// ----
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (e !== g) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wait_for(input logic sel, input logic v, input int lim, output int n);
		n = 0;
		while ((sel ? dn_oe : st_oe) !== v) begin
			@(negedge ref_clk);
			n++;
			if (n > lim) begin
				err_count++;
				$display("MISMATCH wait exp %h got %h", v, ~v);
				tally_and_finish();
			end
		end
	endtask

	always @(posedge cfg_clk)
		prev_din <= din;
	always @(negedge cfg_clk)
		if (chk_chain) begin
			if (idx >= 44 && idx <= 40 + FR * FB - 2)
				check("chain_hi", 16'h0001, chain);
			if (idx >= 40 + FR * FB + 4 && idx < LEN)
				check("chain_pass", prev_din, chain);
		end

	// ----
	// scenarios
	// ----
	task automatic power_up();
		int n;
		@(negedge ref_clk);
		check("hi_cfg", 16'h0001, hi_cfg);
		check("lo_cfg", 16'h0000, lo_cfg);
		wait_for(0, 0, 20000, n);
		check("por_wait", 16'h0001, n >= POR);
	endtask

	task automatic good_config();
		int n;
		@(posedge ref_clk);
		chk_chain = 1'b1;
		run <= 1'b1;
		wait_for(1, 0, 60000, n);
		chk_chain = 1'b0;
		check("len_wait", 16'h0001, n * 5 >= (LEN - 2) * 48);
		check("lo_done", 16'h0001, lo_cfg);
		check("hi_done", 16'h0000, hi_cfg);
	endtask

	task automatic readback();
		logic [15:0] crc;
		logic [10:0] got;
		crc = CRC16_INIT;
		got = '0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge cfg_clk);
			rb_en <= 1'b1;
			rb_bit <= RB_PAT[i];
			crc = {crc[14:0], 1'b0} ^ (crc[15] ^ RB_PAT[i] ? CRC16_POLY : 16'h0000);
		end
		@(posedge cfg_clk);
		rb_en <= 1'b0;
		repeat (30) begin
			@(negedge cfg_clk);
			if (rb_busy)
				got = {got[9:0], rb_data};
		end
		check("rb_crc", crc[15:5], got);
		check("rb_idle", 16'h0001, {rb_busy, rb_data});
	endtask

	task automatic reprogram();
		int n;
		@(posedge ref_clk);
		run <= 1'b0;
		reprogram_n <= 1'b0;
		wait_for(0, 1, 20, n);
		repeat (300) @(negedge ref_clk);
		check("clr_hold", 16'h0001, st_oe);
		@(posedge ref_clk);
		reprogram_n <= 1'b1;
		wait_for(0, 0, 20000, n);
		check("no_por", 16'h0001, n < POR);
		check("dn_oe", 16'h0001, dn_oe);
	endtask

	task automatic bad_frame();
		int n;
		@(posedge ref_clk);
		bad <= 8'h02;
		run <= 1'b1;
		wait_for(0, 1, 20000, n);
		repeat (2000) @(negedge ref_clk);
		check("err_hold", 16'h0001, st_oe);
		check("no_done", 16'h0001, dn_oe);
		reprogram();
	endtask

	// the link domain resets through a synchroniser, so its clock runs during reset
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		reprogram_n = 1'b1;
		run = 1'b1;
		bad = 8'hFF;
		rb_en = 1'b0;
		rb_bit = 1'b0;
		chk_chain = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (6) @(posedge cfg_clk);
		@(posedge ref_clk);
		nrst <= 1'b1;
		run <= 1'b0;
		power_up();
		good_config();
		readback();
		reprogram();
		bad_frame();
		tally_and_finish();
	end
endmodule // config_load_sequencer_test
